// *** rtl/rcc_rtc.sv ***
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`include "rcc_defines.svh"
`default_nettype none
module rcc_rtc
  import rcc_pkg::*;
#(
  parameter int PATTERN_BITS = 128
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic clk32k_in,
  input wire logic one_hz_tick,
  output logic alarm_irq,
  output logic countdown_irq,
  output logic combined_irq
);

  // The pattern registers and the 7-bit index are sized for exactly 128 bits.
  generate
    if (PATTERN_BITS != 128) begin : g_bad_pattern
      $error("rcc_rtc: PATTERN_BITS must be 128");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // A zero in the weekday, day, month or year alarm field means that the field takes no part in the match.
  function automatic logic field_ok(input logic [13:0] now_val, input logic [13:0] alarm_val);
    field_ok = (alarm_val == 14'h0) || (now_val == alarm_val);
  endfunction

  function automatic logic [31:0] year_word(input rcc_year_t y);
    year_word = {18'h0, y};
  endfunction

  function automatic logic [1:0] masked_flags(input logic [1:0] raw, input logic [1:0] mask);
    masked_flags = raw & mask;
  endfunction

  // Set wins over clear, so an event that lands in the clearing cycle is not lost.
  function automatic logic flag_next(input logic held, input logic clear, input logic event_now);
    flag_next = (held & ~clear) | event_now;
  endfunction

  function automatic logic alarm_hit(input rcc_date_t d, input rcc_year_t y,
                                     input rcc_date_t a, input rcc_year_t ay);
    logic hit;
    hit = (d.sec == a.sec) && (d.min == a.min) && (d.hour == a.hour);
    hit = hit && field_ok({11'h0, d.wday}, {11'h0, a.wday});
    hit = hit && field_ok({9'h0, d.mday}, {9'h0, a.mday});
    hit = hit && field_ok({10'h0, d.month}, {10'h0, a.month});
    hit = hit && field_ok(y, ay);
    alarm_hit = hit;
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a, input rcc_state_t s);
    logic [31:0] w;
    w = 32'h0;
    // Unmapped offsets read as zero.
    if (a == `RCC_OFS_DATE_NOW) begin
      w = s.date_now;
    end else if (a == `RCC_OFS_DATE_ALARM) begin
      w = s.date_alarm;
    end else if (a == `RCC_OFS_DATE_LOAD) begin
      w = s.date_load;
    end else if (a == `RCC_OFS_YEAR_NOW) begin
      w = year_word(s.year_now);
    end else if (a == `RCC_OFS_YEAR_ALARM) begin
      w = year_word(s.year_alarm);
    end else if (a == `RCC_OFS_YEAR_LOAD) begin
      w = year_word(s.year_load);
    end else if (a == `RCC_OFS_TRIM) begin
      w = s.trim;
    end else if (a == `RCC_OFS_IRQ_MASK) begin
      w = {30'h0, s.mask};
    end else if (a == `RCC_OFS_RAW_IRQ) begin
      w = {30'h0, s.raw};
    end else if (a == `RCC_OFS_MASKED_IRQ) begin
      w = {30'h0, masked_flags(s.raw, s.mask)};
    end else if (a == `RCC_OFS_IRQ_CLEAR) begin
      w = 32'h0; // The clear register is write-only and reads as zero.
    end else if (a == `RCC_OFS_CD_VALUE) begin
      w = s.cnt;
    end else if (a == `RCC_OFS_CD_CONTROL) begin
      w = {21'h0, s.ctrl};
    end else if (a == `RCC_OFS_RELOAD1) begin
      w = s.reload1;
    end else if (a == `RCC_OFS_RELOAD2) begin
      w = s.reload2;
    end else if (a == `RCC_OFS_PATTERN0) begin
      w = s.pattern[31:0];
    end else if (a == `RCC_OFS_PATTERN1) begin
      w = s.pattern[63:32];
    end else if (a == `RCC_OFS_PATTERN2) begin
      w = s.pattern[95:64];
    end else if (a == `RCC_OFS_PATTERN3) begin
      w = s.pattern[127:96];
    end else if (a == `RCC_OFS_PAT_INDEX) begin
      w = {25'h0, s.pidx};
    end
    read_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  // All state lives in one packed struct; its next value is built in one place below.
  rcc_state_t r_reg;
  rcc_state_t r_next;
  rcc_date_t step_date;
  rcc_year_t step_year;

  // The one-second step is worked out every cycle and used only on a tick.
  rcc_cal_step u_cal_step (
    .cur_date(r_reg.date_now),
    .cur_year(r_reg.year_now),
    .next_date(step_date),
    .next_year(step_year)
  );

  // Reads take one wait state so that hrdata comes from a flip-flop and a read
  // straight after a write already sees the written value.
  assign hreadyout = (r_reg.bus != RCC_BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = r_reg.rdata;
  assign alarm_irq = r_reg.raw[`RCC_IRQ_ALARM];
  assign countdown_irq = r_reg.raw[`RCC_IRQ_COUNTDOWN];
  assign combined_irq = |masked_flags(r_reg.raw, r_reg.mask);

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic tick32;
    logic tick1hz;
    logic wr;
    logic running;
    logic one_shot;
    logic [32:0] dec;
    logic [6:0] plen;
    logic [1:0] clr;
    logic cd_evt;
    logic cal_evt;
    tick32 = 1'b0;
    tick1hz = 1'b0;
    wr = 1'b0;
    running = 1'b0;
    one_shot = 1'b0;
    dec = 33'h0;
    plen = 7'h0;
    clr = 2'h0;
    cd_evt = 1'b0;
    cal_evt = 1'b0;
    r_next = r_reg;

    ////////////////////////////////////////////////////////////////////////
    // Both slow inputs are foreign to clk_sys; edges are taken past stage two.
    // Each level of either pin must last one clk_sys period or a step is lost.
    r_next.s32 = {r_reg.s32[0], clk32k_in};
    r_next.s32_q = r_reg.s32[1];
    r_next.s1hz = {r_reg.s1hz[0], one_hz_tick};
    r_next.s1hz_q = r_reg.s1hz[1];
    tick32 = r_reg.s32[1] & ~r_reg.s32_q;
    tick1hz = r_reg.s1hz[1] & ~r_reg.s1hz_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave.
    // While a read waits hready is low, so no new address phase is taken then.
    wr = (r_reg.bus == RCC_BUS_WR);
    case (r_reg.bus)
      RCC_BUS_RD_WAIT: begin
        r_next.rdata = read_word(r_reg.addr, r_reg);
        r_next.bus = RCC_BUS_RD_DONE;
      end
      default: begin
        if (hsel && htrans[1] && hready) begin
          r_next.addr = haddr[7:0];
          r_next.bus = hwrite ? RCC_BUS_WR : RCC_BUS_RD_WAIT;
        end else begin
          r_next.bus = RCC_BUS_IDLE;
        end
      end
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Countdown.
    // A borrow, a tick that finds the count already at zero, is the zero event.
    // The index restarts at zero on a start by control write and on every first reload write taken,
    // but not on a self-start from a reload two write, which keeps the old index.
    running = r_reg.ctrl[`RCC_CTL_RUN];
    one_shot = r_reg.ctrl[`RCC_CTL_ONE_SHOT];
    plen = r_reg.ctrl[`RCC_CTL_LEN_MSB:`RCC_CTL_LEN_LSB];
    if (running && tick32) begin
      dec = {1'b0, r_reg.cnt} - 33'h1;
      if (dec[32]) begin
        cd_evt = 1'b1;
        if (one_shot) begin
          r_next.cnt = 32'h0;
          r_next.ctrl[`RCC_CTL_RUN] = 1'b0;
        end else begin
          r_next.cnt = r_reg.pattern[r_reg.pidx] ? r_reg.reload2 : r_reg.reload1;
          r_next.pidx = (r_reg.pidx >= plen) ? 7'h0 : r_reg.pidx + 7'h1;
        end
      end else begin
        r_next.cnt = dec[31:0];
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calendar: a pending load replaces the step at the next second.
    // The alarm sees the value about to be stored, so a freshly loaded date can match at once.
    if (tick1hz) begin
      if (r_reg.load_pend) begin
        r_next.date_now = r_reg.date_load;
        r_next.year_now = r_reg.year_load;
        r_next.load_pend = 1'b0;
      end else begin
        r_next.date_now = step_date;
        r_next.year_now = step_year;
      end
      cal_evt = alarm_hit(r_next.date_now, r_next.year_now, r_reg.date_alarm, r_reg.year_alarm);
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes, applied in the data phase.
    // A control write in the cycle of a one-shot borrow wins, as software's request is newer.
    // Reload writes are dropped while the timer runs, so a count in flight is never torn.
    if (wr) begin
      if (r_reg.addr == `RCC_OFS_DATE_ALARM) begin
        r_next.date_alarm = hwdata;
        r_next.date_alarm.rsvd = 3'h0;
      end else if (r_reg.addr == `RCC_OFS_DATE_LOAD) begin
        // The year load is taken together with the date, so write both before the tick.
        r_next.date_load = hwdata;
        r_next.date_load.rsvd = 3'h0;
        r_next.load_pend = 1'b1;
      end else if (r_reg.addr == `RCC_OFS_YEAR_ALARM) begin
        r_next.year_alarm = hwdata[13:0];
      end else if (r_reg.addr == `RCC_OFS_YEAR_LOAD) begin
        r_next.year_load = hwdata[13:0];
      end else if (r_reg.addr == `RCC_OFS_TRIM) begin
        // Trim is storage for software only; nothing in this block uses it.
        r_next.trim = hwdata;
      end else if (r_reg.addr == `RCC_OFS_IRQ_MASK) begin
        r_next.mask = hwdata[1:0];
      end else if (r_reg.addr == `RCC_OFS_IRQ_CLEAR) begin
        clr = hwdata[1:0];
      end else if (r_reg.addr == `RCC_OFS_CD_CONTROL) begin
        r_next.ctrl = hwdata[`RCC_CTL_W-1:0];
        // Starting from stopped by a control write always begins from the first reload value.
        if (!running && hwdata[`RCC_CTL_RUN]) begin
          r_next.cnt = r_reg.reload1;
          r_next.pidx = 7'h0;
        end
      end else if (r_reg.addr == `RCC_OFS_RELOAD1) begin
        if (!running) begin
          r_next.reload1 = hwdata;
          r_next.cnt = hwdata;
          r_next.pidx = 7'h0;
          if (r_reg.ctrl[`RCC_CTL_SELF_START]) begin
            r_next.ctrl[`RCC_CTL_RUN] = 1'b1;
          end
        end
      end else if (r_reg.addr == `RCC_OFS_RELOAD2) begin
        // Reload two leaves the count alone; it is used at a later borrow.
        if (!running) begin
          r_next.reload2 = hwdata;
          if (r_reg.ctrl[`RCC_CTL_SELF_START]) begin
            r_next.ctrl[`RCC_CTL_RUN] = 1'b1;
          end
        end
      end else if (r_reg.addr == `RCC_OFS_PATTERN0) begin
        r_next.pattern[31:0] = hwdata;
      end else if (r_reg.addr == `RCC_OFS_PATTERN1) begin
        r_next.pattern[63:32] = hwdata;
      end else if (r_reg.addr == `RCC_OFS_PATTERN2) begin
        r_next.pattern[95:64] = hwdata;
      end else if (r_reg.addr == `RCC_OFS_PATTERN3) begin
        r_next.pattern[127:96] = hwdata;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags stay until cleared; an event in the clearing cycle survives.
    // Raw flags go out unmasked; the mask gates only the combined line and the masked register.
    r_next.raw[`RCC_IRQ_ALARM] = flag_next(r_reg.raw[`RCC_IRQ_ALARM], clr[`RCC_IRQ_ALARM], cal_evt);
    r_next.raw[`RCC_IRQ_COUNTDOWN] = flag_next(r_reg.raw[`RCC_IRQ_COUNTDOWN], clr[`RCC_IRQ_COUNTDOWN],
                                               cd_evt);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // The synchroniser stages clear with the rest, so a pin that is high at reset gives one edge after it.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r_reg <= '0;
      r_reg.bus <= RCC_BUS_IDLE;
      r_reg.date_now <= `RCC_RST_DATE_NOW;
      r_reg.year_now <= `RCC_RST_YEAR_NOW;
      r_reg.year_alarm <= `RCC_RST_YEAR_ALARM;
      r_reg.trim <= `RCC_RST_TRIM;
      r_reg.cnt <= `RCC_RST_CD_VALUE;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule
`default_nettype wire

// *** rtl/rcc_defines.svh ***
`ifndef RCC_DEFINES_SVH
`define RCC_DEFINES_SVH

// Register byte offsets within the block.
`define RCC_OFS_DATE_NOW 8'h00
`define RCC_OFS_DATE_ALARM 8'h04
`define RCC_OFS_DATE_LOAD 8'h08
`define RCC_OFS_YEAR_NOW 8'h0c
`define RCC_OFS_YEAR_ALARM 8'h10
`define RCC_OFS_YEAR_LOAD 8'h14
`define RCC_OFS_TRIM 8'h18
`define RCC_OFS_IRQ_MASK 8'h1c
`define RCC_OFS_RAW_IRQ 8'h20
`define RCC_OFS_MASKED_IRQ 8'h24
`define RCC_OFS_IRQ_CLEAR 8'h28
`define RCC_OFS_CD_VALUE 8'h2c
`define RCC_OFS_CD_CONTROL 8'h30
`define RCC_OFS_RELOAD1 8'h34
`define RCC_OFS_RELOAD2 8'h38
`define RCC_OFS_PATTERN0 8'h3c
`define RCC_OFS_PATTERN1 8'h40
`define RCC_OFS_PATTERN2 8'h44
`define RCC_OFS_PATTERN3 8'h48
`define RCC_OFS_PAT_INDEX 8'h4c

// Countdown control fields.
`define RCC_CTL_RUN 0
`define RCC_CTL_ONE_SHOT 1
`define RCC_CTL_SELF_START 2
`define RCC_CTL_LEN_LSB 4
`define RCC_CTL_LEN_MSB 10
`define RCC_CTL_W 11

// Interrupt bit positions in mask, raw, masked and clear registers.
`define RCC_IRQ_ALARM 0
`define RCC_IRQ_COUNTDOWN 1

// Reset values.
`define RCC_RST_DATE_NOW 32'h02120000
`define RCC_RST_YEAR_NOW 14'h2000
`define RCC_RST_YEAR_ALARM 14'h2000
`define RCC_RST_TRIM 32'h00007fff
`define RCC_RST_CD_VALUE 32'hffffffff

// Calendar limits.
`define RCC_YEAR_MAX 14'd4096
`define RCC_SEC_MAX 6'd59
`define RCC_HOUR_MAX 5'd23
`define RCC_WDAY_MAX 3'd7
`define RCC_MONTH_MAX 4'd12

`endif

// *** rtl/rcc_pkg.sv ***
`default_nettype none
package rcc_pkg;

  typedef struct packed {
    logic [2:0] rsvd;
    logic [3:0] month;
    logic [4:0] mday;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rcc_date_t;

  typedef logic [13:0] rcc_year_t;

  typedef enum logic [3:0] {
    RCC_BUS_IDLE = 4'b0001,
    RCC_BUS_WR = 4'b0010,
    RCC_BUS_RD_WAIT = 4'b0100,
    RCC_BUS_RD_DONE = 4'b1000
  } rcc_bus_t;

  typedef struct packed {
    rcc_bus_t bus;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [1:0] s32;
    logic s32_q;
    logic [1:0] s1hz;
    logic s1hz_q;
    rcc_date_t date_now;
    rcc_year_t year_now;
    rcc_date_t date_alarm;
    rcc_year_t year_alarm;
    rcc_date_t date_load;
    rcc_year_t year_load;
    logic load_pend;
    logic [31:0] trim;
    logic [1:0] mask;
    logic [1:0] raw;
    logic [31:0] cnt;
    logic [10:0] ctrl;
    logic [31:0] reload1;
    logic [31:0] reload2;
    logic [127:0] pattern;
    logic [6:0] pidx;
  } rcc_state_t;

endpackage
`default_nettype wire

// *** rtl/rcc_cal_step.sv ***
`include "rcc_defines.svh"
`default_nettype none
module rcc_cal_step
  import rcc_pkg::*;
(
  input wire rcc_date_t cur_date,
  input wire rcc_year_t cur_year,
  output rcc_date_t next_date,
  output rcc_year_t next_year
);

  function automatic logic is_leap(input rcc_year_t y);
    is_leap = (y[1:0] == 2'b00) && (((y % 14'd100) != 14'd0) || ((y % 14'd400) == 14'd0));
  endfunction

  function automatic logic [4:0] month_days(input logic [3:0] m, input rcc_year_t y);
    if (m == 4'd2) begin
      month_days = is_leap(y) ? 5'd29 : 5'd28;
    end else if (m == 4'd4 || m == 4'd6 || m == 4'd9 || m == 4'd11) begin
      month_days = 5'd30;
    end else begin
      month_days = 5'd31;
    end
  endfunction

  // Each field wraps to its first value; all but the weekday and the year carry into the next one.
  always_comb begin
    next_date = cur_date;
    next_year = cur_year;
    next_date.rsvd = 3'h0;
    if (cur_date.sec < `RCC_SEC_MAX) begin
      next_date.sec = cur_date.sec + 6'd1;
    end else begin
      next_date.sec = 6'd0;
      if (cur_date.min < `RCC_SEC_MAX) begin
        next_date.min = cur_date.min + 6'd1;
      end else begin
        next_date.min = 6'd0;
        if (cur_date.hour < `RCC_HOUR_MAX) begin
          next_date.hour = cur_date.hour + 5'd1;
        end else begin
          next_date.hour = 5'd0;
          next_date.wday = (cur_date.wday >= `RCC_WDAY_MAX) ? 3'd1 : cur_date.wday + 3'd1;
          if (cur_date.mday < month_days(cur_date.month, cur_year)) begin
            next_date.mday = cur_date.mday + 5'd1;
          end else begin
            next_date.mday = 5'd1;
            if (cur_date.month < `RCC_MONTH_MAX) begin
              next_date.month = cur_date.month + 4'd1;
            end else begin
              next_date.month = 4'd1;
              next_year = (cur_year >= `RCC_YEAR_MAX) ? 14'd0 : cur_year + 14'd1;
            end
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** testbench/rcc_rtc_monitor.sv ***
`default_nettype none
module rcc_rtc_check #(
  parameter int PATTERN_BITS = 128
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic clk32k_in,
  input wire logic one_hz_tick,
  input wire logic alarm_irq,
  input wire logic countdown_irq,
  input wire logic combined_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////////
  logic take;
  logic wr_q;
  logic rd_q;
  logic p1;
  logic p32;
  logic clr_a;
  logic clr_c;
  logic mw;
  logic [7:0] a_q;
  logic [3:0] s1;
  logic [3:0] s32;
  assign take = hsel && htrans[1] && hready;
  assign clr_a = wr_q && a_q == 8'h28 && hwdata[0];
  assign clr_c = wr_q && a_q == 8'h28 && hwdata[1];
  assign mw = wr_q && a_q == 8'h1c;
  // A pin edge restarts a counter, which then saturates so that a late flag is still caught.
  always_ff @(posedge clk_sys) begin
    wr_q <= take && hwrite && !srst;
    rd_q <= take && !hwrite && !srst;
    a_q <= take ? haddr[7:0] : a_q;
    p1 <= one_hz_tick;
    p32 <= clk32k_in;
    s1 <= srst ? 4'hf : (one_hz_tick && !p1) ? 4'h0 : (s1 == 4'hf) ? 4'hf : s1 + 4'h1;
    s32 <= srst ? 4'hf : (clk32k_in && !p32) ? 4'h0 : (s32 == 4'hf) ? 4'hf : s32 + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  AST_HRESP_OKAY: assert property (hresp == 1'b0) else $error("hresp not okay");
  AST_READ_WAIT: assert property (take && !hwrite |=> s_rd_wait) else $error("read wait wrong");
  AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  AST_RDATA_HOLD: assert property (!rd_q |=> $stable(hrdata)) else $error("hrdata moved");
  AST_ALARM_CLEAR: assert property ($fell(alarm_irq) && !$past(srst) |-> $past(clr_a))
    else $error("alarm dropped without clear");
  AST_CD_CLEAR: assert property ($fell(countdown_irq) && !$past(srst) |-> $past(clr_c))
    else $error("countdown dropped without clear");
  AST_ALARM_AFTER_TICK: assert property ($rose(alarm_irq) |-> s1 <= 4'd10) else $error("alarm off tick");
  AST_CD_AFTER_STEP: assert property ($rose(countdown_irq) |-> s32 <= 4'd10) else $error("cd off step");
  AST_COMBINED_OR: assert property (combined_irq |-> alarm_irq || countdown_irq) else $error("combined");
  AST_COMBINED_CAUSE: assert property ($rose(combined_irq) |->
    $rose(alarm_irq) || $rose(countdown_irq) || $past(mw)) else $error("combined rose alone");
endmodule

bind rcc_rtc rcc_rtc_check #(.PATTERN_BITS(PATTERN_BITS)) u_check (
  .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .clk32k_in(clk32k_in), .one_hz_tick(one_hz_tick), .alarm_irq(alarm_irq),
  .countdown_irq(countdown_irq), .combined_irq(combined_irq)
);
`default_nettype wire

// *** testbench/test_rtc_countdown_and_calendar.sv ***
`default_nettype none
module test_rtc_countdown_and_calendar;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d;} rcc_row_t;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic clk32k_in = 1'b0;
  logic one_hz_tick = 1'b0;
  logic hreadyout, hresp, alarm_irq, countdown_irq, combined_irq;
  logic [31:0] hrdata, rd;
  logic [31:0] ld [3];
  logic [31:0] nd [3];
  logic [31:0] ny [3];
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  rcc_row_t rows [16] = '{'{1'b0, 8'h00, 32'h02120000}, '{1'b0, 8'h0c, 32'h2000}, '{1'b0, 8'h10, 32'h2000},
    '{1'b0, 8'h18, 32'h7fff}, '{1'b0, 8'h2c, 32'hffffffff}, '{1'b0, 8'h1c, 32'h0}, '{1'b0, 8'h20, 32'h0},
    '{1'b0, 8'h24, 32'h0}, '{1'b0, 8'h4c, 32'h0}, '{1'b1, 8'h00, 32'h12345678}, '{1'b0, 8'h00, 32'h02120000},
    '{1'b1, 8'h18, 32'habcd}, '{1'b0, 8'h18, 32'habcd}, '{1'b1, 8'h28, 32'h3}, '{1'b0, 8'h28, 32'h0},
    '{1'b0, 8'h50, 32'h0}};

  rcc_rtc #(.PATTERN_BITS(128)) dut (
    .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .clk32k_in(clk32k_in), .one_hz_tick(one_hz_tick), .alarm_irq(alarm_irq),
    .countdown_irq(countdown_irq), .combined_irq(combined_irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      stop_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // Pins are held long enough for the double synchroniser and edge detector to settle.
  task automatic pulse(input bit fast, input int n);
    repeat (n) begin
      if (fast) clk32k_in <= 1'b1;
      else one_hz_tick <= 1'b1;
      repeat (4) @(posedge clk_sys);
      clk32k_in <= 1'b0;
      one_hz_tick <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
  endtask

  function automatic logic [31:0] dt(input int mo, md, wd, h, mi, s);
    return {3'b0, mo[3:0], md[4:0], wd[2:0], h[4:0], mi[5:0], s[5:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ld = '{dt(2, 28, 7, 23, 59, 59), dt(2, 28, 3, 23, 59, 59), dt(12, 31, 1, 23, 59, 59)};
    nd = '{dt(3, 1, 1, 0, 0, 0), dt(2, 29, 4, 0, 0, 0), dt(1, 1, 2, 0, 0, 0)};
    ny = '{32'd2023, 32'd2024, 32'd2024};
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk($sformatf("reg %h", rows[i].a), rd, rows[i].d);
    end
    // One-shot from three: three steps reach zero, the fourth borrows and halts.
    wr(8'h34, 32'h3);
    rdc("cd load", 8'h2c, 32'h3);
    wr(8'h30, 32'h3);
    pulse(1, 3);
    chk("cd irq early", countdown_irq, 1'b0);
    rdc("cd zero", 8'h2c, 32'h0);
    pulse(1, 1);
    chk("cd irq", countdown_irq, 1'b1);
    rdc("cd control", 8'h30, 32'h2);
    pulse(1, 2);
    rdc("cd halted", 8'h2c, 32'h0);
    rdc("masked off", 8'h24, 32'h0);
    chk("combined off", combined_irq, 1'b0);
    wr(8'h1c, 32'h3);
    rdc("raw", 8'h20, 32'h2);
    rdc("masked on", 8'h24, 32'h2);
    chk("combined on", combined_irq, 1'b1);
    wr(8'h28, 32'h2);
    rdc("raw cleared", 8'h20, 32'h0);
    // Periodic with pattern bits 0 then 1 over a two-bit cycle.
    wr(8'h30, 32'h0);
    wr(8'h34, 32'h2);
    wr(8'h38, 32'h5);
    wr(8'h3c, 32'h2);
    wr(8'h30, 32'h11);
    wr(8'h34, 32'h9);
    rdc("reload kept", 8'h34, 32'h2);
    pulse(1, 3);
    rdc("pattern idx", 8'h4c, 32'h1);
    rdc("reload first", 8'h2c, 32'h2);
    wr(8'h28, 32'h2);
    pulse(1, 3);
    rdc("reload second", 8'h2c, 32'h5);
    rdc("pattern wrap", 8'h4c, 32'h0);
    wr(8'h30, 32'h6);
    wr(8'h34, 32'h1);
    rdc("self start", 8'h30, 32'h7);
    rdc("self load", 8'h2c, 32'h1);
    wr(8'h30, 32'h0);
    // Alarm on March 1st at midnight; weekday and year are left out of the match.
    wr(8'h04, dt(3, 1, 0, 0, 0, 0));
    wr(8'h10, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(8'h08, ld[i]);
      wr(8'h14, ny[i] - ((i == 2) ? 32'd1 : 32'd0));
      pulse(0, 1);
      rdc("date load", 8'h00, ld[i]);
      pulse(0, 1);
      rdc("date step", 8'h00, nd[i]);
      rdc("year step", 8'h0c, ny[i]);
      chk("alarm", alarm_irq, i == 0);
      wr(8'h28, 32'h1);
    end
    srst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    chk("irqs after reset", {alarm_irq, countdown_irq, combined_irq}, 3'b0);
    rdc("cd after reset", 8'h2c, 32'hffffffff);
    stop_test;
  end
endmodule
`default_nettype wire
